//--- rtl/csw_status_bank.sv
// Controller status word bank with AHB-Lite slave and fault interrupt
//
// Overview of operation
// - Memory fault word: bits 4,6,9,12 flag faults
// - Arrangement word bit 8 flags illegal arrangement
// - Save word bit 1: second RAM save lost
// - Save word bit 3: registration lost
// - Save word bit 8 shows write mode
// - Save word bit 9: RAM differs from storage
// - Summary config error bit follows arrangement word
//
// The AHB-Lite interface to the registers was left to the implementer.
`include "csw_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module csw_status_bank (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Fault and mode levels from the controller core
  input  wire csw_pkg::csw_status_in_t status_in,
  // AHB-Lite slave
  input  wire csw_pkg::csw_ahb_req_t   ahb_req,
  output var  csw_pkg::csw_ahb_rsp_t   ahb_rsp,
  // Interrupt
  output var  logic                    irq
);
  import csw_pkg::*;

  csw_state_t s_reg;  // Registered state
  csw_state_t s_next; // Next state

  // Pack synchronised levels into event sources in interrupt bit order
  function automatic logic [6:0] src_vec(input csw_status_in_t v);
    src_vec = {v.ram_differs, v.registration_lost, v.second_ram_save, v.illegal_arrange,
               v.model_mismatch, v.model_data_fault | v.setting_fault, v.nvm_fault};
  endfunction

  // Register index from a byte address; upper bits must be clear for a hit
  function automatic logic [7:0] addr_idx(input logic [31:0] a);
    addr_idx = a[9:2];
  endfunction

  // Readback mux, unmapped indexes read zero
  function automatic logic [31:0] read_mux(input csw_state_t st, input logic [7:0] i);
    case (i)
      `CSW_IDX_MEMORY_FAULT:      read_mux = {16'h0000, st.mem_word};
      `CSW_IDX_ARRANGEMENT_FAULT: read_mux = {16'h0000, st.arr_word};
      `CSW_IDX_SAVE_AND_WRITE:    read_mux = {16'h0000, st.saw_word};
      `CSW_IDX_SUMMARY:           read_mux = {16'h0000, st.sum_word};
      `CSW_IDX_IRQ_STATUS:        read_mux = {25'h0000000, st.irq_stat};
      `CSW_IDX_IRQ_MASK:          read_mux = {25'h0000000, st.irq_mask};
      default:                    read_mux = 32'h00000000;
    endcase
  endfunction

  // Next state: synchronise, build words, serve bus, track events
  always_comb begin
    logic        take;
    logic [6:0]  cur_src;
    logic [6:0]  rise;
    logic [6:0]  clr;
    take    = 1'b0;
    cur_src = 7'h00;
    rise    = 7'h00;
    clr     = 7'h00;
    s_next  = s_reg;

    // Two flop synchroniser; only stage two feeds logic
    s_next.sync1 = status_in;
    s_next.sync2 = s_reg.sync1;

    // Status words rebuilt each cycle; all unused positions forced zero
    s_next.mem_word = `CSW_WORD_RESET;
    s_next.mem_word[`CSW_BIT_NVM_FAULT]        = s_reg.sync2.nvm_fault;
    s_next.mem_word[`CSW_BIT_SETTING_FAULT]    = s_reg.sync2.setting_fault;
    s_next.mem_word[`CSW_BIT_MODEL_DATA_FAULT] = s_reg.sync2.model_data_fault;
    s_next.mem_word[`CSW_BIT_MODEL_MISMATCH]   = s_reg.sync2.model_mismatch;

    s_next.arr_word = `CSW_WORD_RESET;
    s_next.arr_word[`CSW_BIT_ILLEGAL_ARRANGE] = s_reg.sync2.illegal_arrange;

    s_next.saw_word = `CSW_WORD_RESET;
    s_next.saw_word[`CSW_BIT_SECOND_RAM_SAVE]   = s_reg.sync2.second_ram_save;
    s_next.saw_word[`CSW_BIT_REGISTRATION_LOST] = s_reg.sync2.registration_lost;
    s_next.saw_word[`CSW_BIT_WRITE_MODE]        = s_reg.sync2.ram_write_mode;
    s_next.saw_word[`CSW_BIT_RAM_DIFFERS]       = s_reg.sync2.ram_differs;

    // Summary is built from the registered detail words, so it lags them by one cycle
    s_next.sum_word = `CSW_WORD_RESET;
    s_next.sum_word[`CSW_BIT_SUM_DEVICE_ERR] = |s_reg.mem_word;
    s_next.sum_word[`CSW_BIT_SUM_CONFIG_ERR] = |s_reg.arr_word;

    // Rising fault levels are events
    cur_src       = src_vec(s_reg.sync2);
    rise          = cur_src & ~s_reg.prev_src;
    s_next.prev_src = cur_src;

    // Address phase accepted when selected, ready and NONSEQ
    take = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == `CSW_HTRANS_NONSEQ);

    // Data phase completes in the cycle after the address phase
    s_next.rd_pend = 1'b0;
    s_next.wr_pend = 1'b0;
    if (s_reg.rd_pend) begin
      // Read of interrupt status clears only the bits the master was shown;
      // an event raised after the snapshot survives, and set wins over the clear
      if (s_reg.idx == `CSW_IDX_IRQ_STATUS) begin
        clr = s_reg.hrdata[6:0];
      end
    end
    if (s_reg.wr_pend) begin
      // Only the mask takes writes; status words ignore them
      if (s_reg.idx == `CSW_IDX_IRQ_MASK) begin
        s_next.irq_mask = ahb_req.hwdata[6:0];
      end
    end
    if (take) begin
      s_next.idx     = (ahb_req.haddr[31:10] == 22'h000000) ? addr_idx(ahb_req.haddr) : 8'hFF;
      s_next.rd_pend = !ahb_req.hwrite;
      s_next.wr_pend = ahb_req.hwrite;
      // Read data captured now so it is stable during the data phase
      s_next.hrdata  = ahb_req.hwrite ? 32'h00000000 :
                       read_mux(s_reg, s_next.idx);
    end

    s_next.irq_stat = (s_reg.irq_stat & ~clr) | rise;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Read data and interrupt straight from flops; ready and response tied off, so slave never inserts wait states
  always_comb begin
    ahb_rsp.hrdata    = s_reg.hrdata;
    ahb_rsp.hreadyout = 1'b1;
    ahb_rsp.hresp     = 1'b0;
    irq               = s_reg.irq;
  end
endmodule
`default_nettype wire

//--- rtl/csw_defs.svh
// Register offsets, field positions and reset values of the controller status words
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH
// Printed offsets are register indexes; byte address is four times the index
`define CSW_IDX_MEMORY_FAULT      8'h01
`define CSW_IDX_ARRANGEMENT_FAULT 8'h02
`define CSW_IDX_SAVE_AND_WRITE    8'h13
`define CSW_IDX_SUMMARY           8'h00
`define CSW_IDX_IRQ_STATUS        8'h20
`define CSW_IDX_IRQ_MASK          8'h21
// Memory fault status fields
`define CSW_BIT_NVM_FAULT         4
`define CSW_BIT_SETTING_FAULT     6
`define CSW_BIT_MODEL_DATA_FAULT  9
`define CSW_BIT_MODEL_MISMATCH    12
// Arrangement fault status field
`define CSW_BIT_ILLEGAL_ARRANGE   8
// Save and write status fields
`define CSW_BIT_SECOND_RAM_SAVE   1
`define CSW_BIT_REGISTRATION_LOST 3
`define CSW_BIT_WRITE_MODE        8
`define CSW_BIT_RAM_DIFFERS       9
// Summary word fields
`define CSW_BIT_SUM_DEVICE_ERR    0
`define CSW_BIT_SUM_CONFIG_ERR    1
// Interrupt status bits (one per fault source; setting and model data faults share one bit)
`define CSW_IRQ_WIDTH             7
`define CSW_IRQ_RESET             7'h00
`define CSW_WORD_RESET            16'h0000
// AHB encodings
`define CSW_HTRANS_NONSEQ         2'h2
`define CSW_HSIZE_WORD            3'h2
`endif

//--- rtl/csw_pkg.sv
// Types shared by the controller status word bank
package csw_pkg;
  // Raw fault and mode inputs from the controller core
  typedef struct packed {
    logic nvm_fault;          // Non-volatile storage fault
    logic setting_fault;      // Setting value fault
    logic model_data_fault;   // Model information data fault
    logic model_mismatch;     // Model information mismatch
    logic illegal_arrange;    // Unit left of head end unit
    logic second_ram_save;    // Power lost during second RAM area save
    logic registration_lost;  // Power lost during registration
    logic ram_write_mode;     // 1 = RAM only writes
    logic ram_differs;        // RAM differs from stored copy
  } csw_status_in_t;

  // AHB-Lite slave side request
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } csw_ahb_req_t;

  // AHB-Lite slave side response
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } csw_ahb_rsp_t;

  // Whole module state
  typedef struct packed {
    csw_status_in_t                 sync1;      // First synchroniser stage
    csw_status_in_t                 sync2;      // Second synchroniser stage
    logic [15:0]                    mem_word;   // Memory fault status word
    logic [15:0]                    arr_word;   // Arrangement fault word
    logic [15:0]                    saw_word;   // Save and write status word
    logic [15:0]                    sum_word;   // Summary word
    logic [6:0]                     irq_stat;   // Sticky event bits
    logic [6:0]                     irq_mask;   // Interrupt enables
    logic [6:0]                     prev_src;   // Previous fault levels
    logic                           rd_pend;    // Read data phase pending
    logic                           wr_pend;    // Write data phase pending
    logic [7:0]                     idx;        // Latched register index
    logic [31:0]                    hrdata;     // Read data out
    logic                           irq;        // Interrupt line
  } csw_state_t;
endpackage

//--- verification/csw_status_asserts.sv
// Port assertions for the controller status word bank
`timescale 1ns/10ps
`default_nettype none
module csw_status_asserts (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Watched ports
  input wire csw_pkg::csw_status_in_t status_in,
  input wire csw_pkg::csw_ahb_req_t   ahb_req,
  input wire csw_pkg::csw_ahb_rsp_t   ahb_rsp,
  input wire logic                    irq
);
  import csw_pkg::*;
  logic [2:0]     stab_reg; // Quiet cycles of the inputs, saturating
  csw_status_in_t p_reg;    // Inputs one cycle back
  logic           rd_any;   // Read address phase taken
  logic           rd_go;    // Read taken once the words have settled
  // Words lag the inputs by the synchroniser, so only settled reads are judged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stab_reg <= 3'h0;
      p_reg    <= '0;
    end else begin
      p_reg    <= status_in;
      stab_reg <= (status_in != p_reg) ? 3'h0 : stab_reg + {2'h0, stab_reg != 3'h7};
    end
  end
  assign rd_any = ahb_req.hsel & ahb_req.hready & (ahb_req.htrans == 2'h2) & !ahb_req.hwrite;
  assign rd_go  = rd_any & (stab_reg >= 3'h5) & (ahb_req.haddr[31:10] == 22'h0);
  sequence rd_at(logic [7:0] i);
    rd_go && (ahb_req.haddr[9:2] == i);
  endsequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  mem_word_a: assert property (rd_at(8'h01) |=> ahb_rsp.hrdata == 32'({p_reg.model_mismatch, 2'h0,
    p_reg.model_data_fault, 2'h0, p_reg.setting_fault, 1'b0, p_reg.nvm_fault, 4'h0}))
    else $error("memory fault word wrong");
  arr_word_a: assert property (rd_at(8'h02) |=> ahb_rsp.hrdata == 32'({p_reg.illegal_arrange, 8'h00}))
    else $error("arrangement word wrong");
  save_low_a: assert property (rd_at(8'h13) |=> ahb_rsp.hrdata[3:0] ==
    {p_reg.registration_lost, 1'b0, p_reg.second_ram_save, 1'b0}) else $error("save bits wrong");
  save_mode_a: assert property (rd_at(8'h13) |=> ahb_rsp.hrdata[9:8] ==
    {p_reg.ram_differs, p_reg.ram_write_mode}) else $error("mode bits wrong");
  save_unused_a: assert property (rd_at(8'h13) |=> {ahb_rsp.hrdata[31:10], ahb_rsp.hrdata[7:4]} == 26'h0)
    else $error("unused save bits set");
  summary_cfg_a: assert property (rd_at(8'h00) |=> ahb_rsp.hrdata[1] == p_reg.illegal_arrange)
    else $error("summary config bit wrong");
  data_stands_a: assert property (!(ahb_req.hsel && ahb_req.hready && ahb_req.htrans == 2'h2)
    |=> $stable(ahb_rsp.hrdata))
    else $error("read data moved without a read");
  resp_okay_a: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp) else $error("not ready or not okay");
  irq_quiet_a: assert property ($fell(rst) |-> !irq) else $error("interrupt after reset");
endmodule
`default_nettype wire

//--- verification/csw_status_bank_tb.sv
// Self-checking bench for the controller status word bank
`timescale 1ns/10ps
`default_nettype none
module csw_status_bank_tb;
  import csw_pkg::*;
  logic           clk, rst, irq;
  csw_status_in_t st, s;    // Driven levels and their expected copy
  csw_ahb_req_t   rq;
  csw_ahb_rsp_t   rs;
  int             failures, compares;
  logic [31:0]    d;
  localparam logic [7:0] IX [3] = '{8'h01, 8'h02, 8'h13};
  csw_status_bank i_csw_status_bank (.clk(clk), .rst(rst), .status_in(st), .ahb_req(rq),
    .ahb_rsp(rs), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic complete_run();
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready is sampled at each rising edge; the wait is bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (rs.hreadyout !== 1'b1 && n < 50);
    if (rs.hreadyout !== 1'b1) begin
      failures++;
      complete_run();
    end
  endtask
  // One single word transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] ix, input logic [31:0] wd, output logic [31:0] rd);
    rq.hsel   <= 1'b1;
    rq.htrans <= 2'h2;
    rq.hwrite <= wr;
    rq.haddr  <= {22'h0, ix, 2'h0};
    wait_rdy();
    rq.htrans <= 2'h0;
    rq.hwdata <= wd;
    wait_rdy();
    rd = rs.hrdata;
  endtask
  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk(32'(irq), 32'(e));
    @(posedge clk);
  endtask
  initial begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    st  = '0;
    rq  = '0;
    rq.hready = 1'b1; // Sole slave, so its own ready is the bus ready
    rq.hsize  = 3'h2;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, 8'h21, 32'h0, d);
    chk(d, 32'h0);
    // Walk each source alone, then all at once, with writes that must not stick
    for (int k = 0; k <= 9; k++) begin
      s = (k == 9) ? 9'h1FF : 9'(9'h1 << k);
      st <= s;
      repeat (8) @(posedge clk);
      foreach (IX[j]) xfer(1'b1, IX[j], 32'hFFFF_FFFF, d);
      xfer(1'b0, 8'h01, 32'h0, d);
      chk(d, 32'({s.model_mismatch, 2'h0, s.model_data_fault, 2'h0, s.setting_fault, 1'b0, s.nvm_fault, 4'h0}));
      xfer(1'b0, 8'h02, 32'h0, d);
      chk(d, 32'({s.illegal_arrange, 8'h00}));
      xfer(1'b0, 8'h13, 32'h0, d);
      chk(d, 32'({s.ram_differs, s.ram_write_mode, 4'h0, s.registration_lost, 1'b0, s.second_ram_save, 1'b0}));
      xfer(1'b0, 8'h00, 32'h0, d);
      chk(32'(d[1]), 32'(s.illegal_arrange));
      chk(32'(d[0]), 32'(s.nvm_fault | s.setting_fault | s.model_data_fault | s.model_mismatch));
      chk_irq(1'b0);
    end
    xfer(1'b0, 8'hC0, 32'h0, d);
    chk(d, 32'h0);
    // Events: unmasked one raises the line, a status read clears it
    st <= '0;
    repeat (8) @(posedge clk);
    xfer(1'b0, 8'h20, 32'h0, d);
    xfer(1'b1, 8'h21, 32'h8, d);
    st.nvm_fault <= 1'b1;
    repeat (8) @(posedge clk);
    chk_irq(1'b0);
    st.illegal_arrange <= 1'b1;
    repeat (8) @(posedge clk);
    chk_irq(1'b1);
    xfer(1'b0, 8'h20, 32'h0, d);
    chk(d, 32'h9);
    chk_irq(1'b0);
    complete_run();
  end
endmodule
bind csw_status_bank csw_status_asserts i_csw_status_asserts (.clk, .rst, .status_in, .ahb_req,
  .ahb_rsp, .irq);
`default_nettype wire
